// ---- tcd_pkg.sv ----
// Shared constants and state carriers for the transition code channel decoder
package tcd_pkg;
	// APB register byte offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_MASK = 12'h008;
	localparam logic [11:0] OFS_STATE = 12'h00c;
	// Control register fields and reset value
	localparam int CTRL_BALANCED = 0;
	localparam logic CTRL_RESET = 1'h1;
	// Status / mask bits: four error sources and compare completion
	localparam int EV_W = 5;
	localparam int EV_DATA1 = 0;
	localparam int EV_COMPL = 1;
	localparam int EV_ACTIVITY = 2;
	localparam int EV_DRIVER = 3;
	localparam int EV_CMP_DONE = 4;
	localparam int ERR_W = 4;
	// Synchronised pin inputs, one slot each
	localparam int SYNC_W = 8;
	localparam int IN_WCLK = 0;
	localparam int IN_DATA_N = 1;
	localparam int IN_TRIG = 2;
	localparam int IN_STEST_N = 3;
	localparam int IN_ERST_N = 4;
	localparam int IN_RCLK = 5;
	localparam int IN_DCLK = 6;
	localparam int IN_HALF = 7;
	// Elastic store geometry
	localparam int ADDR_W = 4;
	localparam int DEPTH = 16;
	localparam int CODE_W = 3;
	localparam logic [1:0] CODE_LAST = 2'h2;
	// Activity monitor timeout
	localparam int CLK_PERIOD_NS = 10;
	localparam int ACT_TIMEOUT_NS = 2000;
	localparam int ACT_CYCLES = ACT_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int ACT_W = 8;

	// One transition decoder path
	typedef struct packed {
		logic [CODE_W-1:0] code;
		logic pend;
		logic first_half;
		logic level;
		logic out;
	} dec_t;

	// Address compare diagnostic
	typedef struct packed {
		logic [ADDR_W-1:0] lat_addr;
		logic lat_data;
		logic busy;
		logic arm;
		logic enable;
		logic match;
	} cmp_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;
endpackage

// ---- transition_code_channel_decoder.sv ----
// Transition code channel decoder with elastic store, diagnostics and APB control
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module transition_code_channel_decoder (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic channel_data_in_n,
	input wire logic gated_write_clock,
	input wire logic compare_trigger_w24b0,
	input wire logic self_test_n,
	input wire logic error_reset_n,
	input wire logic read_clock,
	input wire logic decode_clock_2x,
	input wire logic half_rate_clock,
	output logic channel_data_out_p,
	output logic channel_data_out_n,
	output logic card_error_stuff_req_n
);
	typedef struct packed {
		logic [tcd_pkg::SYNC_W-1:0] sync1;
		logic [tcd_pkg::SYNC_W-1:0] sync2;
		logic [tcd_pkg::SYNC_W-1:0] prev;
		logic [tcd_pkg::DEPTH-1:0] store;
		logic [tcd_pkg::ADDR_W-1:0] wr_addr;
		logic [tcd_pkg::ADDR_W-1:0] rd_addr;
		logic [1:0] phase;
		tcd_pkg::dec_t dec1;
		tcd_pkg::dec_t dec2;
		tcd_pkg::cmp_t cmp;
		logic [tcd_pkg::ACT_W-1:0] act_cnt;
		logic [tcd_pkg::ERR_W-1:0] err;
		logic card_err_n;
		logic balanced;
		logic out_p;
		logic out_n;
		logic [tcd_pkg::EV_W-1:0] status;
		logic [tcd_pkg::EV_W-1:0] mask;
		logic irq;
		tcd_pkg::apb_rsp_t rsp;
	} state_t;

	state_t s;
	state_t n;

	logic [tcd_pkg::SYNC_W-1:0] pins;
	assign pins = {
		half_rate_clock,
		decode_clock_2x,
		read_clock,
		error_reset_n,
		self_test_n,
		compare_trigger_w24b0,
		channel_data_in_n,
		gated_write_clock
	};

	// Rising edge of a synchronised input; reads the second stage and the prev stage behind it
	function automatic logic rise(input state_t st, input int idx);
		rise = st.sync2[idx] & ~st.prev[idx];
	endfunction

	// One decoder step: shift on read clock, act on the double-rate clock
	function automatic tcd_pkg::dec_t dec_step(input tcd_pkg::dec_t d, input logic rd_edge,
			input logic bit_in, input logic last, input logic mark_val,
			input logic dclk_edge, input logic half_lvl);
		tcd_pkg::dec_t r;
		r = d;
		if (dclk_edge && d.pend && (half_lvl == d.first_half)) begin
			r.out = d.level;
			r.pend = 1'b0;
		end
		if (rd_edge) begin
			r.code = {d.code[tcd_pkg::CODE_W-2:0], bit_in};
			if (last) begin
				r.pend = (r.code[2] == mark_val);
				r.first_half = (r.code[1] == mark_val);
				r.level = r.code[0];
			end
		end
		return r;
	endfunction

	// Register select for one offset; shared by write and refusal decode, reads decode by case
	function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
		hit = (addr == ofs);
	endfunction

	// Read data for one register; unmapped offsets read as zero
	function automatic logic [31:0] read_word(input state_t st, input logic [11:0] addr);
		logic [31:0] r;
		r = '0;
		unique case (addr)
			tcd_pkg::OFS_CTRL: r = {31'h0, st.balanced};
			tcd_pkg::OFS_STATUS: r = {27'h0, st.status};
			tcd_pkg::OFS_MASK: r = {27'h0, st.mask};
			tcd_pkg::OFS_STATE: begin
				r = {11'h0,
					st.err,
					1'h0,
					st.dec2.out,
					st.dec1.out,
					st.card_err_n,
					st.cmp.busy,
					st.cmp.lat_addr,
					st.rd_addr,
					st.wr_addr};
			end
			default: r = '0;
		endcase
		return r;
	endfunction

	always_comb begin
		logic wclk_e;
		logic rclk_e;
		logic dclk_e;
		logic trig_e;
		logic stest;
		logic erst;
		logic rd_bit;
		logic last;
		logic [tcd_pkg::ADDR_W-1:0] wr_last;
		logic [tcd_pkg::ERR_W-1:0] err_set;
		logic done;
		logic acc;
		logic wr;
		logic mapped;
		wclk_e = 1'b0;
		rclk_e = 1'b0;
		dclk_e = 1'b0;
		trig_e = 1'b0;
		stest = 1'b0;
		erst = 1'b0;
		rd_bit = 1'b0;
		last = 1'b0;
		wr_last = '0;
		err_set = '0;
		done = 1'b0;
		acc = 1'b0;
		wr = 1'b0;
		mapped = 1'b0;
		n = s;

		n.sync1 = pins;
		n.sync2 = s.sync1;
		n.prev = s.sync2;
		wclk_e = rise(s, tcd_pkg::IN_WCLK);
		rclk_e = rise(s, tcd_pkg::IN_RCLK);
		dclk_e = rise(s, tcd_pkg::IN_DCLK);
		trig_e = rise(s, tcd_pkg::IN_TRIG);
		stest = ~s.sync2[tcd_pkg::IN_STEST_N];
		erst = ~s.sync2[tcd_pkg::IN_ERST_N];

		// Elastic store write side
		if (wclk_e) begin
			n.store[s.wr_addr] = ~s.sync2[tcd_pkg::IN_DATA_N];
			n.wr_addr = s.wr_addr + 1'b1;
		end

		// Read side; relies on the read clock tracking the write clock count
		rd_bit = s.store[s.rd_addr];
		last = (s.phase == tcd_pkg::CODE_LAST);
		if (rclk_e) begin
			n.rd_addr = s.rd_addr + 1'b1;
			n.phase = last ? 2'h0 : s.phase + 2'h1;
		end
		n.dec1 = dec_step(s.dec1, rclk_e, rd_bit, last, 1'b1, dclk_e,
			s.sync2[tcd_pkg::IN_HALF]);
		// Duplicate path decodes the inverted stream, so its output is the complement
		n.dec2 = dec_step(s.dec2, rclk_e, ~rd_bit, last, 1'b0, dclk_e,
			s.sync2[tcd_pkg::IN_HALF]);

		// Address compare; the bit that was just written is the one latched
		wr_last = s.wr_addr - 1'b1;
		if (trig_e && !s.cmp.busy) begin
			n.cmp.lat_addr = wr_last;
			n.cmp.lat_data = s.store[wr_last];
			n.cmp.busy = 1'b1;
			n.cmp.arm = 1'b1;
		end
		if (rclk_e) begin
			if (s.cmp.arm) begin
				n.cmp.arm = 1'b0;
				n.cmp.enable = 1'b1;
			end
			if (s.cmp.enable && s.rd_addr == s.cmp.lat_addr) begin
				n.cmp.enable = 1'b0;
				n.cmp.match = 1'b1;
			end
			if (s.cmp.match) begin
				n.cmp.match = 1'b0;
				n.cmp.busy = 1'b0;
				done = 1'b1;
				// Decoder register still holds the matched bit before this shift
				err_set[tcd_pkg::EV_DATA1] = (s.cmp.lat_data != s.dec1.code[0])
					| stest;
			end
		end

		err_set[tcd_pkg::EV_COMPL] = (s.dec1.out == s.dec2.out);

		// Retriggerable activity monitor on the output timing clock
		if (dclk_e) begin
			n.act_cnt = '0;
		end else if (s.act_cnt != tcd_pkg::ACT_W'(tcd_pkg::ACT_CYCLES)) begin
			n.act_cnt = s.act_cnt + 1'b1;
		end
		err_set[tcd_pkg::EV_ACTIVITY] =
			(s.act_cnt == tcd_pkg::ACT_W'(tcd_pkg::ACT_CYCLES));

		// Driver stage self-check on the registered pin levels
		err_set[tcd_pkg::EV_DRIVER] = s.balanced ? (s.out_p == s.out_n)
			: s.out_n;

		// Error latch; a fresh error wins over a simultaneous reset
		if (erst && !stest) begin
			n.err = '0;
		end
		n.err = n.err | err_set;
		n.card_err_n = ~|n.err;

		// APB slave with one wait state
		acc = psel & penable;
		wr = acc & s.rsp.pready & pwrite;
		mapped = hit(paddr, tcd_pkg::OFS_CTRL) || hit(paddr, tcd_pkg::OFS_STATUS)
			|| hit(paddr, tcd_pkg::OFS_MASK) || hit(paddr, tcd_pkg::OFS_STATE);
		// Refusal only in the wait cycle, so pslverr pulses with pready
		n.rsp.pready = acc & ~s.rsp.pready;
		n.rsp.pslverr = acc & ~s.rsp.pready & ~mapped;
		n.rsp.prdata = '0;
		if (acc && !s.rsp.pready && !pwrite) begin
			n.rsp.prdata = read_word(s, paddr);
		end
		if (wr && hit(paddr, tcd_pkg::OFS_CTRL)) begin
			n.balanced = pwdata[tcd_pkg::CTRL_BALANCED];
		end
		// Output pair follows the new mode at once, so the driver check
		// never sees a pair left over from the old mode
		n.out_p = s.dec1.out;
		n.out_n = n.balanced ? ~s.dec1.out : 1'b0;
		if (wr && hit(paddr, tcd_pkg::OFS_MASK)) begin
			n.mask = pwdata[tcd_pkg::EV_W-1:0];
		end
		if (wr && hit(paddr, tcd_pkg::OFS_STATUS)) begin
			n.status = s.status & ~pwdata[tcd_pkg::EV_W-1:0];
		end
		// Events are set after the clear so none is lost
		n.status = n.status | {done, err_set};
		n.irq = |(n.status & n.mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.sync1 <= '1;
			s.sync2 <= '1;
			s.prev <= '1;
			s.dec2.out <= 1'b1;
			s.card_err_n <= 1'b1;
			s.balanced <= tcd_pkg::CTRL_RESET;
			s.out_n <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign prdata = s.rsp.prdata;
	assign pready = s.rsp.pready;
	assign pslverr = s.rsp.pslverr;
	assign irq = s.irq;
	assign channel_data_out_p = s.out_p;
	assign channel_data_out_n = s.out_n;
	assign card_error_stuff_req_n = s.card_err_n;
endmodule // transition_code_channel_decoder

// ---- tcd_far_end.sv ----
// Far-end model: gated write clock, channel data and loop clocks
`timescale 1ns/1ps
module tcd_far_end (
	input wire logic run,
	output logic channel_data_in_n,
	output logic gated_write_clock,
	output logic read_clock,
	output logic decode_clock_2x,
	output logic half_rate_clock
);
	// Codes 111 then 100, first bit first
	localparam logic [5:0] CODES = 6'h0f;
	int n;
	initial begin
		n = 0;
		channel_data_in_n = 1'h1;
		gated_write_clock = 1'h0;
		read_clock = 1'h0;
		decode_clock_2x = 1'h0;
		half_rate_clock = 1'h0;
		forever begin
			wait (run === 1'h1);
			#2;
			half_rate_clock = 1'h1;
			decode_clock_2x = 1'h1;
			read_clock = 1'h0;
			channel_data_in_n = ~CODES[n % 6];
			#40;
			decode_clock_2x = 1'h0;
			gated_write_clock = 1'h1;
			#40;
			half_rate_clock = 1'h0;
			decode_clock_2x = 1'h1;
			gated_write_clock = 1'h0;
			// Reads trail writes by eight bits, same count thereafter
			read_clock = (n >= 8);
			#40;
			decode_clock_2x = 1'h0;
			channel_data_in_n = ~channel_data_in_n;
			#38;
			n++;
		end
	end
endmodule // tcd_far_end

// ---- transition_code_channel_decoder_properties.sv ----
// Pin-level checker for the channel decoder
`timescale 1ns/1ps
module tcd_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic decode_clock_2x,
	input wire logic self_test_n,
	input wire logic error_reset_n,
	input wire logic channel_data_out_p,
	input wire logic channel_data_out_n,
	input wire logic card_error_stuff_req_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("wait state wrong");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
	a_out_pair: assert property (!(channel_data_out_p && channel_data_out_n))
		else $error("outputs both high");
	a_out_hold: assert property ($stable(decode_clock_2x)[*8] |=> $stable(channel_data_out_p))
		else $error("output moved without decode clock");
	a_err_sticky: assert property (
		error_reset_n[*4] ##0 !card_error_stuff_req_n |=> !card_error_stuff_req_n)
		else $error("error dropped without reset");
	a_err_clear: assert property (
		(self_test_n && !error_reset_n)[*8] |=> card_error_stuff_req_n)
		else $error("error reset ignored");
endmodule // tcd_checker

bind transition_code_channel_decoder tcd_checker i_chk (.pclk, .presetn, .psel, .penable,
	.prdata, .pready, .pslverr, .decode_clock_2x, .self_test_n, .error_reset_n,
	.channel_data_out_p, .channel_data_out_n, .card_error_stuff_req_n);

// ---- transition_code_channel_decoder_tb.sv ----
// Self-checking bench for the channel decoder
`timescale 1ns/1ps
module transition_code_channel_decoder_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, run, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic channel_data_in_n, gated_write_clock, compare_trigger_w24b0, self_test_n;
	logic error_reset_n, read_clock, decode_clock_2x, half_rate_clock;
	logic channel_data_out_p, channel_data_out_n, card_error_stuff_req_n;
	int fails, comparisons;
	transition_code_channel_decoder i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .channel_data_in_n,
		.gated_write_clock, .compare_trigger_w24b0, .self_test_n, .error_reset_n,
		.read_clock, .decode_clock_2x, .half_rate_clock, .channel_data_out_p,
		.channel_data_out_n, .card_error_stuff_req_n);
	tcd_far_end i_far (.run, .channel_data_in_n, .gated_write_clock, .read_clock,
		.decode_clock_2x, .half_rate_clock);
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	task automatic ck(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'h1 && k < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (k == 50) fails++;
	endtask
	task automatic pulse_trig;
		@(posedge pclk);
		compare_trigger_w24b0 <= 1'h1;
		repeat (4) @(posedge pclk);
		compare_trigger_w24b0 <= 1'h0;
	endtask
	task automatic err_reset;
		@(posedge pclk);
		error_reset_n <= 1'h0;
		repeat (10) @(posedge pclk);
		error_reset_n <= 1'h1;
		repeat (6) @(posedge pclk);
	endtask
	task automatic wbusy;
		for (int i = 0; i < 60; i++) begin
			ap(1'h0, tcd_pkg::OFS_STATE, 32'h0);
			if (q[12] === 1'h0) break;
			repeat (8) @(posedge pclk);
		end
		ck(q & 32'h1000, 32'h0, "compare stuck");
	endtask
	task automatic t_regs;
		ap(1'h0, tcd_pkg::OFS_CTRL, 32'h0);
		ck(q, 32'h1, "ctrl reset");
		ap(1'h0, tcd_pkg::OFS_MASK, 32'h0);
		ck(q, 32'h0, "mask reset");
		ap(1'h0, 12'h010, 32'h0);
		ck({31'h0, e}, 32'h1, "unmapped not refused");
		$display("t_regs done");
	endtask
	task automatic t_decode;
		int r;
		logic pv;
		r = 0;
		pv = channel_data_out_p;
		// Pattern toggles twice per 96 cycles
		repeat (800) begin
			@(negedge pclk);
			r += (channel_data_out_p !== pv);
			pv = channel_data_out_p;
			if (channel_data_out_n !== ~pv) r += 100;
		end
		ck({31'h0, r >= 8 && r < 100}, 32'h1, "decode toggles");
		ck({31'h0, card_error_stuff_req_n}, 32'h1, "false error");
		ap(1'h1, tcd_pkg::OFS_CTRL, 32'h0);
		repeat (3) @(posedge pclk);
		ck({31'h0, channel_data_out_n}, 32'h0, "unbalanced out_n");
		ap(1'h1, tcd_pkg::OFS_CTRL, 32'h1);
		$display("t_decode done");
	endtask
	task automatic t_compare;
		logic [3:0] la;
		pulse_trig();
		ap(1'h0, tcd_pkg::OFS_STATE, 32'h0);
		la = q[11:8];
		ck({31'h0, q[12]}, 32'h1, "compare not busy");
		// Let the write address move on, so an overwrite would show
		repeat (20) @(posedge pclk);
		pulse_trig();
		ap(1'h0, tcd_pkg::OFS_STATE, 32'h0);
		ck({28'h0, q[11:8]}, {28'h0, la}, "latch overwritten");
		wbusy();
		ap(1'h0, tcd_pkg::OFS_STATUS, 32'h0);
		ck(q & 32'h11, 32'h10, "compare result");
		ck({31'h0, card_error_stuff_req_n}, 32'h1, "false card error");
		ap(1'h1, tcd_pkg::OFS_STATUS, 32'h1f);
		$display("t_compare done");
	endtask
	task automatic t_selftest;
		@(posedge pclk);
		self_test_n <= 1'h0;
		pulse_trig();
		wbusy();
		ck({31'h0, card_error_stuff_req_n}, 32'h0, "self-test no error");
		ap(1'h1, tcd_pkg::OFS_MASK, 32'h1);
		repeat (2) @(posedge pclk);
		ck({31'h0, irq}, 32'h1, "irq not raised");
		ap(1'h1, tcd_pkg::OFS_STATUS, 32'h1);
		repeat (2) @(posedge pclk);
		ck({31'h0, irq}, 32'h0, "irq not cleared");
		ap(1'h1, tcd_pkg::OFS_MASK, 32'h0);
		self_test_n <= 1'h1;
		repeat (10) @(posedge pclk);
		ck({31'h0, card_error_stuff_req_n}, 32'h0, "error not held");
		err_reset();
		ck({31'h0, card_error_stuff_req_n}, 32'h1, "error not reset");
		$display("t_selftest done");
	endtask
	task automatic t_activity;
		@(posedge pclk);
		run <= 1'h0;
		repeat (300) @(posedge pclk);
		ck({31'h0, card_error_stuff_req_n}, 32'h0, "no activity error");
		ap(1'h0, tcd_pkg::OFS_STATUS, 32'h0);
		ck({31'h0, q[2]}, 32'h1, "activity status");
		run <= 1'h1;
		repeat (50) @(posedge pclk);
		err_reset();
		ck({31'h0, card_error_stuff_req_n}, 32'h1, "activity not reset");
		$display("t_activity done");
	endtask
	task automatic finish_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#500000;
		fails++;
		finish_test();
	end
	initial begin
		fails = 0;
		comparisons = 0;
		{psel, penable, pwrite, compare_trigger_w24b0} = 4'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		{self_test_n, error_reset_n, run} = 3'h6;
		presetn = 1'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		// Far end starts with the block out of reset, so no code bit is lost
		run <= 1'h1;
		t_regs();
		t_decode();
		t_compare();
		t_selftest();
		t_activity();
		finish_test();
	end
endmodule // transition_code_channel_decoder_tb
